// ---- verilog/tmrb_pkg.sv ----
package tmrb_pkg;
    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_CONTROL_A = 4'h0;
    localparam logic [3:0] IDX_CONTROL_B = 4'h1;
    localparam logic [3:0] IDX_EVENT_CONTROL = 4'h4;
    localparam logic [3:0] IDX_INTERRUPT_ENABLE = 4'h5;
    localparam logic [3:0] IDX_INTERRUPT_FLAGS = 4'h6;
    localparam logic [3:0] IDX_RUN_STATE = 4'h7;
    localparam logic [3:0] IDX_DEBUG_CONTROL = 4'h8;
    localparam logic [3:0] IDX_TEMPORARY_BYTE = 4'h9;
    localparam logic [3:0] IDX_COUNTER_LO = 4'ha;
    localparam logic [3:0] IDX_COUNTER_HI = 4'hb;
    localparam logic [3:0] IDX_COMPARE_LO = 4'hc;
    localparam logic [3:0] IDX_COMPARE_HI = 4'hd;
    // Field positions
    localparam int BIT_ENABLE = 0;
    localparam int BIT_CLOCK_SELECT_LO = 1;
    localparam int BIT_FOLLOW_A = 4;
    localparam int BIT_STANDBY_RUN = 6;
    localparam int BIT_OUT_EN = 4;
    localparam int BIT_INIT_LVL = 5;
    localparam int BIT_IMMEDIATE = 6;
    localparam int BIT_EVENT_EN = 0;
    localparam int BIT_EDGE = 4;
    localparam int BIT_FILTER = 6;
    localparam int BIT_CAPTURE = 0;
    localparam int BIT_DBG_RUN = 0;
    // Writable masks and reset values
    localparam logic [7:0] MASK_CONTROL_A = 8'h57;
    localparam logic [7:0] MASK_CONTROL_B = 8'h77;
    localparam logic [7:0] MASK_EVENT_CONTROL = 8'h51;
    localparam logic [7:0] MASK_BIT0 = 8'h01;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;
    // Mode and clock select codes
    typedef enum logic [2:0] {
        MODE_PERIODIC = 3'h0, MODE_TIMEOUT = 3'h1, MODE_CAPTURE_EVT = 3'h2,
        MODE_CAPTURE_FRQ = 3'h3, MODE_CAPTURE_PW = 3'h4, MODE_CAPTURE_FPW = 3'h5,
        MODE_SINGLE_SHOT = 3'h6, MODE_PWM8 = 3'h7
    } count_mode_t;
    typedef enum logic [1:0] {
        CLK_PERIPH = 2'h0, CLK_PERIPH_DIV2 = 2'h1, CLK_TYPE_A = 2'h2, CLK_RESERVED = 2'h3
    } clock_source_t;
    localparam int FILTER_SAMPLES = 4;
    localparam int TRIGGER_DELAY = 2;
    // Captured AHB address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic mapped;
        logic [3:0] index;
    } ahb_addr_t;
endpackage

// ---- verilog/timer_b.sv ----
`timescale 1ns/1ps
`default_nettype none
module timer_b
    import tmrb_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    input wire logic event_i,
    input wire logic type_a_tick_i,
    input wire logic type_a_restart_i,
    input wire logic sleep_standby_i,
    input wire logic sleep_powerdown_i,
    input wire logic cpu_halted_i,
    output logic wave_o,
    output logic event_o,
    output logic irq_o
);
    logic [7:0] ctrl_a_q, ctrl_b_q, evctl_q, inten_q, dbg_q, temp_q;
    logic [15:0] cnt_q, cmp_q;
    logic flag_q, run_q, hold_q, trig_q, immediate_output_on_event_q, en_prev_q, div_q, pwm_q, event_q;
    logic [FILTER_SAMPLES-1:0] sr_q;
    logic filt_q, sel_prev_q, raw_prev_q;
    ahb_addr_t ap_q;
    logic wt_q;
    logic [31:0] hrdata_q;

    count_mode_t mode;
    clock_source_t csel;
    logic enabled, active, tick, ss, pwm, oen;
    logic sel_sig, edge_hit, raw_edge, ev_take, immediate_output_on_event_hit, capture_flag_set;
    logic bus_do, bus_wr, bus_rd, cnt_wr;
    logic [7:0] lo, hi, rbyte;

    assign mode = count_mode_t'(ctrl_b_q[2:0]);
    assign csel = clock_source_t'(ctrl_a_q[BIT_CLOCK_SELECT_LO +: 2]);
    assign enabled = ctrl_a_q[BIT_ENABLE];
    assign ss = enabled && (mode == MODE_SINGLE_SHOT);
    assign pwm = enabled && (mode == MODE_PWM8);
    assign oen = ctrl_b_q[BIT_OUT_EN];
    assign lo = cmp_q[7:0];
    assign hi = cmp_q[15:8];

    // Power-down, and standby or debug halt while their run bits are clear, gate all counting
    assign active = enabled && !sleep_powerdown_i
        && !(sleep_standby_i && !ctrl_a_q[BIT_STANDBY_RUN])
        && !(cpu_halted_i && !dbg_q[BIT_DBG_RUN]);

    always_comb begin
        case (csel)
            CLK_PERIPH: tick = active;
            CLK_PERIPH_DIV2: tick = active && div_q;
            CLK_TYPE_A: tick = active && type_a_tick_i;
            default: tick = 1'b0;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q <= 1'b0;
        end else begin
            div_q <= active ? !div_q : 1'b0;
        end
    end

    // Noise filter on the undivided clock
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sr_q <= '0;
            filt_q <= 1'b0;
        end else begin
            sr_q <= {sr_q[FILTER_SAMPLES-2:0], event_i};
            if ((&sr_q) || !(|sr_q)) begin
                filt_q <= sr_q[FILTER_SAMPLES-1];
            end
        end
    end

    assign sel_sig = evctl_q[BIT_FILTER] ? filt_q : event_i;
    assign edge_hit = evctl_q[BIT_EDGE] ? (sel_prev_q && !sel_sig) : (!sel_prev_q && sel_sig);
    // Events only act while enabled, stopped and outside the post-match tick
    assign ev_take = ss && evctl_q[BIT_EVENT_EN] && edge_hit && !run_q && !hold_q
        && !trig_q;
    // Unaligned path: a level change shorter than a clock can still be seen here, since raw_edge reaches wave_o unregistered
    assign raw_edge = evctl_q[BIT_EDGE] ? (raw_prev_q && !event_i) : (!raw_prev_q && event_i);
    assign immediate_output_on_event_hit = ss && ctrl_b_q[BIT_IMMEDIATE] && evctl_q[BIT_EVENT_EN] && raw_edge
        && !run_q && !hold_q && !trig_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sel_prev_q <= 1'b0;
            raw_prev_q <= 1'b0;
        end else begin
            sel_prev_q <= sel_sig;
            raw_prev_q <= event_i;
        end
    end

    // AHB-Lite slave, one wait state per transfer
    assign bus_do = ap_q.valid && !wt_q;
    assign bus_wr = bus_do && ap_q.write && ap_q.mapped;
    assign bus_rd = bus_do && !ap_q.write && ap_q.mapped;
    assign cnt_wr = bus_wr && (ap_q.index == IDX_COUNTER_HI);
    assign hreadyout_o = !ap_q.valid || wt_q;
    assign hresp_o = 1'b0;
    assign hrdata_o = hrdata_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ap_q <= '0;
            wt_q <= 1'b0;
        end else begin
            if (hready_i) begin
                ap_q.valid <= hsel_i && htrans_i[1];
                ap_q.write <= hwrite_i;
                ap_q.mapped <= (haddr_i[31:6] == 26'h0) && (haddr_i[1:0] == 2'h0);
                ap_q.index <= haddr_i[5:2];
                wt_q <= 1'b0;
            end else if (ap_q.valid) begin
                wt_q <= 1'b1;
            end
        end
    end

    always_comb begin
        case (ap_q.index)
            IDX_CONTROL_A: rbyte = ctrl_a_q;
            IDX_CONTROL_B: rbyte = ctrl_b_q;
            IDX_EVENT_CONTROL: rbyte = evctl_q;
            IDX_INTERRUPT_ENABLE: rbyte = inten_q;
            IDX_INTERRUPT_FLAGS: rbyte = {7'h00, flag_q};
            IDX_RUN_STATE: rbyte = {7'h00, run_q};
            IDX_DEBUG_CONTROL: rbyte = dbg_q;
            IDX_TEMPORARY_BYTE: rbyte = temp_q;
            IDX_COUNTER_LO: rbyte = cnt_q[7:0];
            IDX_COUNTER_HI: rbyte = temp_q;
            IDX_COMPARE_LO: rbyte = cmp_q[7:0];
            IDX_COMPARE_HI: rbyte = temp_q;
            default: rbyte = RESET_BYTE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hrdata_q <= 32'h0;
        end else if (bus_do) begin
            hrdata_q <= bus_rd ? {24'h0, rbyte} : 32'h0;
        end
    end

    // Control registers
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_a_q <= RESET_BYTE;
            ctrl_b_q <= RESET_BYTE;
            evctl_q <= RESET_BYTE;
            inten_q <= RESET_BYTE;
            dbg_q <= RESET_BYTE;
        end else if (bus_wr) begin
            case (ap_q.index)
                IDX_CONTROL_A: ctrl_a_q <= hwdata_i[7:0] & MASK_CONTROL_A;
                IDX_CONTROL_B: ctrl_b_q <= hwdata_i[7:0] & MASK_CONTROL_B;
                IDX_EVENT_CONTROL: evctl_q <= hwdata_i[7:0] & MASK_EVENT_CONTROL;
                IDX_INTERRUPT_ENABLE: inten_q <= hwdata_i[7:0] & MASK_BIT0;
                IDX_DEBUG_CONTROL: dbg_q <= hwdata_i[7:0] & MASK_BIT0;
                default: ;
            endcase
        end
    end

    // Temporary byte: low-byte write parks data, low-byte read parks the high half
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            temp_q <= RESET_BYTE;
        end else if (bus_wr && (ap_q.index == IDX_TEMPORARY_BYTE || ap_q.index == IDX_COUNTER_LO
                || ap_q.index == IDX_COMPARE_LO)) begin
            temp_q <= hwdata_i[7:0];
        end else if (bus_rd && ap_q.index == IDX_COUNTER_LO) begin
            temp_q <= cnt_q[15:8];
        end else if (bus_rd && ap_q.index == IDX_COMPARE_LO) begin
            temp_q <= cmp_q[15:8];
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cmp_q <= RESET_WORD;
        end else if (bus_wr && ap_q.index == IDX_COMPARE_HI) begin
            cmp_q <= {hwdata_i[7:0], temp_q};
        end
    end

    // Single-shot sequencing: event, two-clock trigger pipeline, run until match
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trig_q <= 1'b0;
            run_q <= 1'b0;
            hold_q <= 1'b0;
            immediate_output_on_event_q <= 1'b0;
            en_prev_q <= 1'b0;
        end else begin
            en_prev_q <= ss;
            trig_q <= ev_take;
            if (!ss) begin
                run_q <= 1'b0;
                hold_q <= 1'b0;
                immediate_output_on_event_q <= 1'b0;
            end else begin
                if (immediate_output_on_event_hit) begin
                    immediate_output_on_event_q <= 1'b1;
                end else if (trig_q) begin
                    immediate_output_on_event_q <= 1'b0;
                end
                if (trig_q || !en_prev_q) begin
                    run_q <= 1'b1;
                end else if (run_q && tick && cnt_q == cmp_q) begin
                    run_q <= 1'b0;
                    hold_q <= 1'b1;
                end else if (hold_q && tick) begin
                    hold_q <= 1'b0;
                end
            end
        end
    end

    // Counter: bus write, then restarts, then counting
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= RESET_WORD;
        end else if (cnt_wr) begin
            cnt_q <= {hwdata_i[7:0], temp_q};
        end else if (enabled && ctrl_a_q[BIT_FOLLOW_A] && type_a_restart_i) begin
            cnt_q <= RESET_WORD;
        end else if (ss && trig_q) begin
            cnt_q <= RESET_WORD;
        end else if (tick) begin
            if (ss) begin
                if (run_q && cnt_q != cmp_q) begin
                    cnt_q <= cnt_q + 16'h1;
                end
            end else if (pwm) begin
                cnt_q <= (cnt_q[7:0] == lo) ? RESET_WORD : {8'h00, cnt_q[7:0] + 8'h1};
            end else begin
                cnt_q <= cnt_q + 16'h1;
            end
        end
    end

    // PWM level; zero bytes force low, high above count keeps it high
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pwm_q <= 1'b0;
        end else begin
            pwm_q <= pwm && (lo != 8'h00) && (hi != 8'h00)
                && (cnt_q[7:0] < hi);
        end
    end

    always_comb begin
        if (!oen) begin
            wave_o = 1'b0;
        end else if (ss) begin
            wave_o = run_q || immediate_output_on_event_q || immediate_output_on_event_hit;
        end else if (pwm) begin
            wave_o = pwm_q;
        end else begin
            wave_o = ctrl_b_q[BIT_INIT_LVL];
        end
    end

    // Capture flag, event strobe and interrupt; a set beats a same-cycle clear
    assign capture_flag_set = tick && ((ss && run_q && cnt_q == cmp_q)
        || (pwm && cnt_q[7:0] == lo));

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flag_q <= 1'b0;
            event_q <= 1'b0;
        end else begin
            event_q <= capture_flag_set;
            if (capture_flag_set) begin
                flag_q <= 1'b1;
            end else if (bus_wr && ap_q.index == IDX_INTERRUPT_FLAGS
                    && hwdata_i[BIT_CAPTURE]) begin
                flag_q <= 1'b0;
            end
        end
    end

    assign event_o = event_q;
    assign irq_o = flag_q && inten_q[BIT_CAPTURE];

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_taken;
        ev_take && !cnt_wr && !ctrl_b_q[BIT_IMMEDIATE];
    endsequence
    sequence s_held_ss;
        ss && oen && !bus_wr;
    endsequence

    a_ss_trig_delay: assert property (s_taken ##0 s_held_ss ##1 s_held_ss[*2]
        |-> run_q && wave_o && !$past(wave_o, 2))
        else $error("single-shot output not high two cycles after event");
    a_ss_stopped_low: assert property (ss && oen && !run_q && !immediate_output_on_event_q && !immediate_output_on_event_hit
        |-> !wave_o)
        else $error("single-shot output high while stopped");
    a_ss_match_stop: assert property (ss && run_q && tick && cnt_q == cmp_q && !bus_wr
        |=> !run_q && hold_q && flag_q)
        else $error("single-shot did not stop at compare");
    a_ss_ignore: assert property (hold_q && edge_hit |-> !ev_take)
        else $error("event taken during post-match interval");
    a_pwm_wrap: assert property (pwm && tick && cnt_q[7:0] == lo && !bus_wr
        && !(ctrl_a_q[BIT_FOLLOW_A] && type_a_restart_i) |=> cnt_q == RESET_WORD)
        else $error("pwm counter did not wrap at low byte");
    a_pwm_zero: assert property (pwm && oen && (lo == 8'h00 || hi == 8'h00) ##1
        pwm && oen |-> !wave_o)
        else $error("pwm output high with a zero compare byte");
    a_out_disable: assert property (!oen |-> !wave_o)
        else $error("output driven while disabled");
    a_init_level: assert property (oen && !ss && !pwm
        |-> wave_o == ctrl_b_q[BIT_INIT_LVL])
        else $error("output differs from initial level");
    a_event_strobe: assert property (capture_flag_set |=> event_o && flag_q)
        else $error("capture set without event strobe");
    a_filter_pass: assert property ((evctl_q[BIT_FILTER] && event_i)[*4]
        |=> ##1 filt_q)
        else $error("filter did not pass four equal samples");
    a_type_a_restart: assert property (enabled && ctrl_a_q[BIT_FOLLOW_A]
        && type_a_restart_i && !cnt_wr |=> cnt_q == RESET_WORD)
        else $error("counter did not follow type A restart");
    a_irq_hold: assert property (flag_q && inten_q[BIT_CAPTURE] && !bus_wr |=> irq_o)
        else $error("interrupt request dropped without clear");
    a_sleep_halt: assert property (sleep_powerdown_i && !bus_wr && !trig_q
        && !(ctrl_a_q[BIT_FOLLOW_A] && type_a_restart_i) |=> $stable(cnt_q))
        else $error("counter moved in power-down");
endmodule // timer_b
`default_nettype wire

// ---- test/evt_net_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module evt_net_model (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic level_i,
    input wire logic restart_i,
    input wire logic [3:0] tick_div_i,
    output logic event_o,
    output logic tick_o,
    output logic restart_o
);
    logic [3:0] div_q;
    // Requests are re-timed to an edge, so an event always stands whole cycles
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            event_o <= 1'b0;
            restart_o <= 1'b0;
        end else begin
            event_o <= level_i;
            restart_o <= restart_i;
        end
    end
    // Companion timer prescaled tick, one pulse every tick_div_i clocks
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q <= 4'h0;
            tick_o <= 1'b0;
        end else if (div_q >= tick_div_i - 4'h1) begin
            div_q <= 4'h0;
            tick_o <= 1'b1;
        end else begin
            div_q <= div_q + 4'h1;
            tick_o <= 1'b0;
        end
    end
endmodule // evt_net_model
`default_nettype wire

// ---- test/tb_timer_b_oneshot_pwm_events.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_timer_b_oneshot_pwm_events import tmrb_pkg::*; ;
    typedef struct {
        logic [7:0] ca, lo, hi;
        logic st, pd, rs;
        int er, eh;
    } pwm_case_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic ev_req = 1'b0;
    logic ra_req = 1'b0;
    logic stby = 1'b0;
    logic pdn = 1'b0;
    logic [7:0] rv;
    int fails = 0;
    int samples_checked = 0;
    int r, h, e;
    wire logic hrdy, hresp, ev, tick, ra, wave, evo, irq;
    wire logic [31:0] hrdata;
    logic [3:0] ri [8] = '{IDX_CONTROL_A, IDX_CONTROL_B, IDX_EVENT_CONTROL, IDX_INTERRUPT_ENABLE,
        IDX_INTERRUPT_FLAGS, IDX_RUN_STATE, IDX_DEBUG_CONTROL, IDX_TEMPORARY_BYTE};
    // Enable/clock word, low byte, high byte, standby, power-down, restart, rises, high cycles
    pwm_case_t pc [11] = '{
        '{8'h01, 8'h04, 8'h02, 1'b0, 1'b0, 1'b0, 20, 40},
        '{8'h01, 8'h04, 8'h00, 1'b0, 1'b0, 1'b0, 0, 0},
        '{8'h01, 8'h04, 8'h05, 1'b0, 1'b0, 1'b0, 0, 100},
        '{8'h01, 8'h00, 8'h03, 1'b0, 1'b0, 1'b0, 0, 0},
        '{8'h03, 8'h04, 8'h02, 1'b0, 1'b0, 1'b0, 10, 40},
        '{8'h05, 8'h04, 8'h02, 1'b0, 1'b0, 1'b0, 5, 40},
        '{8'h01, 8'h04, 8'h02, 1'b1, 1'b0, 1'b0, 0, -1},
        '{8'h41, 8'h04, 8'h02, 1'b1, 1'b0, 1'b0, 20, 40},
        '{8'h41, 8'h04, 8'h02, 1'b0, 1'b1, 1'b0, 0, -1},
        '{8'h11, 8'h04, 8'h02, 1'b0, 1'b0, 1'b1, 0, 100},
        '{8'h01, 8'h04, 8'h02, 1'b0, 1'b0, 1'b1, 20, 40}};

    always #5 clk = ~clk;

    evt_net_model i_net (.ref_clk_i(clk), .rst_n_i(rst_n), .level_i(ev_req), .restart_i(ra_req),
        .tick_div_i(4'h4), .event_o(ev), .tick_o(tick), .restart_o(ra));

    timer_b i_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata),
        .event_i(ev), .type_a_tick_i(tick), .type_a_restart_i(ra), .sleep_standby_i(stby),
        .sleep_powerdown_i(pdn), .cpu_halted_i(1'b0), .wave_o(wave), .event_o(evo), .irq_o(irq));

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Single word transfer; waits on hready, never on a fixed count
    task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge clk); while (hrdy !== 1'b1);
        rv = hrdata[7:0];
    endtask

    task automatic wr(input logic [3:0] i, input logic [7:0] d);
        xfer(1'b1, {26'h0, i, 2'h0}, d);
    endtask

    task automatic rdc(input logic [3:0] i, input logic [7:0] x);
        xfer(1'b0, {26'h0, i, 2'h0}, 8'h00);
        chk($sformatf("reg %h", i), {8'h00, rv}, {8'h00, x});
    endtask

    // Counts rises, high cycles and strobes over n settled samples
    task automatic meas(input int n);
        logic p;
        p = wave;
        r = 0;
        h = 0;
        e = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (wave === 1'b1 && p !== 1'b1) r++;
            if (wave === 1'b1) h++;
            if (evo === 1'b1) e++;
            p = wave;
        end
    endtask

    task automatic fire(input logic lv, input int n, input int x, input string nm);
        @(posedge clk) ev_req <= lv;
        meas(n);
        chk(nm, 16'(h), 16'(x));
    endtask

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        foreach (ri[i]) rdc(ri[i], RESET_BYTE);
        wr(IDX_CONTROL_B, 8'hff);
        rdc(IDX_CONTROL_B, MASK_CONTROL_B);
        wr(IDX_RUN_STATE, 8'hff);
        rdc(IDX_RUN_STATE, 8'h00);
        xfer(1'b1, 32'h40, 8'hff);
        xfer(1'b0, 32'h40, 8'h00);
        chk("unmapped", {8'h00, rv}, 16'h0);
        chk("okay response", {15'h0, hresp}, 16'h0);
        rdc(4'h2, 8'h00);
        $display("test registers done");
        wr(IDX_CONTROL_B, 8'h16);
        wr(IDX_COMPARE_LO, 8'h40);
        wr(IDX_COMPARE_HI, 8'h00);
        wr(IDX_COUNTER_LO, 8'h40);
        wr(IDX_COUNTER_HI, 8'h00);
        wr(IDX_EVENT_CONTROL, 8'h01);
        wr(IDX_CONTROL_A, 8'h01);
        fire(1'b0, 10, 0, "idle wave");
        fire(1'b1, 10, 8, "sync start");
        rdc(IDX_RUN_STATE, 8'h01);
        // Pulse lasts compare plus one (65) cycles; 8 were seen, 5 passed on the bus
        fire(1'b0, 150, 52, "run end");
        chk("strobes", 16'(e), 16'h1);
        chk("wave end", {15'h0, wave}, 16'h0);
        rdc(IDX_COUNTER_LO, 8'h40);
        rdc(IDX_COUNTER_HI, 8'h00);
        chk("irq masked", {15'h0, irq}, 16'h0);
        rdc(IDX_INTERRUPT_FLAGS, 8'h01);
        wr(IDX_INTERRUPT_ENABLE, 8'h01);
        chk("irq set", {15'h0, irq}, 16'h1);
        wr(IDX_INTERRUPT_FLAGS, 8'h01);
        chk("irq clear", {15'h0, irq}, 16'h0);
        $display("test single_shot done");
        wr(IDX_EVENT_CONTROL, 8'h10);
        fire(1'b1, 10, 0, "input off rise");
        fire(1'b0, 10, 0, "input off fall");
        wr(IDX_EVENT_CONTROL, 8'h11);
        fire(1'b1, 10, 0, "wrong edge");
        fire(1'b0, 10, 8, "falling edge");
        meas(150);
        wr(IDX_CONTROL_B, 8'h56);
        wr(IDX_EVENT_CONTROL, 8'h01);
        fire(1'b1, 10, 10, "immediate");
        meas(150);
        @(posedge clk) ev_req <= 1'b0;
        wr(IDX_CONTROL_B, 8'h16);
        wr(IDX_EVENT_CONTROL, 8'h41);
        fire(1'b1, 2, 0, "glitch");
        fire(1'b0, 12, 0, "glitch dropped");
        @(posedge clk) ev_req <= 1'b1;
        meas(14);
        chk("filter delay", 16'(h == 7 || h == 8), 16'h1);
        meas(150);
        $display("test event_input done");
        wr(IDX_CONTROL_B, 8'h30);
        chk("initial level", {15'h0, wave}, 16'h1);
        wr(IDX_CONTROL_B, 8'h20);
        chk("output off", {15'h0, wave}, 16'h0);
        // Compare changes follow the safe order: stop, load, zero count, restart
        foreach (pc[i]) begin
            wr(IDX_CONTROL_A, 8'h00);
            wr(IDX_COMPARE_LO, pc[i].lo);
            wr(IDX_COMPARE_HI, pc[i].hi);
            wr(IDX_COUNTER_LO, 8'h00);
            wr(IDX_COUNTER_HI, 8'h00);
            wr(IDX_CONTROL_B, 8'h17);
            stby <= pc[i].st;
            pdn <= pc[i].pd;
            ra_req <= pc[i].rs;
            wr(IDX_CONTROL_A, pc[i].ca);
            meas(20);
            meas(100);
            chk($sformatf("rises %0d", i), 16'(r), 16'(pc[i].er));
            if (pc[i].eh >= 0) chk($sformatf("high %0d", i), 16'(h), 16'(pc[i].eh));
            if (i == 0) chk("pwm strobes", 16'(e), 16'd20);
        end
        $display("test pwm done");
        tally_and_finish;
    end

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        tally_and_finish;
    end
endmodule // tb_timer_b_oneshot_pwm_events
`default_nettype wire
